// >>> qsm_top.sv
`timescale 1ns/1ps
module qsm_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [qsm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [qsm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [qsm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic cls_valid,
    input wire logic [5:0] cls_dscp,
    input wire logic [qsm_pkg::PRIO_W-1:0] cls_qos_prio,
    input wire logic cls_ptp_event,
    input wire logic cls_ptp_general,
    input wire logic cls_is_igmp,
    input wire logic cls_is_ipv6,
    input wire logic [7:0] cls_next_hdr,
    input wire logic [7:0] cls_hbh_next_hdr,
    input wire logic cls_src_match,
    input wire logic cls_dst_match,
    output logic res_valid,
    output logic [qsm_pkg::PRIO_W-1:0] res_prio,
    output logic res_dscp_hit,
    output logic res_to_host,
    output logic res_mirror,
    output logic [1:0] wred_red_dscp,
    output logic [1:0] wred_yellow_dscp,
    output logic [1:0] wred_green_dscp
);
    import qsm_pkg::*;

    logic [MAP_N-1:0][MAP_W-1:0] dscp_map_ff;
    logic ipv4_snoop_ff;
    logic ipv6_snoop_ff;
    logic mld_sel_ff;
    logic mirror_and_ff;
    logic ptp_evt_ovr_ff;
    logic [PRIO_W-1:0] ptp_evt_prio_ff;
    logic ptp_gen_ovr_ff;
    logic [PRIO_W-1:0] ptp_gen_prio_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [PRIO_W-1:0] nxt_prio;
    logic nxt_dscp_hit;
    logic nxt_to_host;
    logic nxt_mirror;
    logic wr_map0;
    logic wr_map1;
    logic wr_map2;
    logic wr_snoop;
    logic wr_wred;
    logic wr_ptp_evt;
    logic wr_ptp_gen;

    qsm_cfg_if cfg_bus ();

    assign cfg_bus.dscp_map = dscp_map_ff;
    assign cfg_bus.ipv4_group_snoop_en = ipv4_snoop_ff;
    assign cfg_bus.ipv6_listener_snoop_en = ipv6_snoop_ff;
    assign cfg_bus.mld_criteria_select = mld_sel_ff;
    assign cfg_bus.mirror_and_mode = mirror_and_ff;
    assign cfg_bus.ptp_event_ovr = ptp_evt_ovr_ff;
    assign cfg_bus.ptp_event_prio = ptp_evt_prio_ff;
    assign cfg_bus.ptp_general_ovr = ptp_gen_ovr_ff;
    assign cfg_bus.ptp_general_prio = ptp_gen_prio_ff;

    qsm_prio_sel u_prio (
        .dscp(cls_dscp),
        .qos_prio(cls_qos_prio),
        .ptp_event(cls_ptp_event),
        .ptp_general(cls_ptp_general),
        .cfg(cfg_bus),
        .prio(nxt_prio),
        .dscp_hit(nxt_dscp_hit)
    );

    qsm_snoop_mirror u_snoop (
        .is_igmp(cls_is_igmp),
        .is_ipv6(cls_is_ipv6),
        .next_hdr(cls_next_hdr),
        .hbh_next_hdr(cls_hbh_next_hdr),
        .src_match(cls_src_match),
        .dst_match(cls_dst_match),
        .cfg(cfg_bus),
        .to_host(nxt_to_host),
        .mirror(nxt_mirror)
    );

    // Write decode
    always_comb begin
        wr_map0 = 1'b0;
        wr_map1 = 1'b0;
        wr_map2 = 1'b0;
        wr_snoop = 1'b0;
        wr_wred = 1'b0;
        wr_ptp_evt = 1'b0;
        wr_ptp_gen = 1'b0;
        if (!reg_wr) begin
            wr_map0 = 1'b0;
        end else if (reg_addr == OFF_MAP_3A_3B) begin
            wr_map0 = 1'b1;
        end else if (reg_addr == OFF_MAP_3C_3D) begin
            wr_map1 = 1'b1;
        end else if (reg_addr == OFF_MAP_3E_3F) begin
            wr_map2 = 1'b1;
        end else if (reg_addr == OFF_MIRROR_SNOOP) begin
            wr_snoop = 1'b1;
        end else if (reg_addr == OFF_WRED_COLOUR) begin
            wr_wred = 1'b1;
        end else if (reg_addr == OFF_PTP_EVENT) begin
            wr_ptp_evt = 1'b1;
        end else if (reg_addr == OFF_PTP_GENERAL) begin
            wr_ptp_gen = 1'b1;
        end
    end

    // Reserved bits have no storage, so writes there vanish
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < MAP_N; i++) begin
                dscp_map_ff[i] <= MAP_RESET;
            end
        end else if (wr_map0) begin
            dscp_map_ff[0] <= reg_wdata[MAP_LO_POS +: MAP_W];
            dscp_map_ff[1] <= reg_wdata[MAP_HI_POS +: MAP_W];
        end else if (wr_map1) begin
            dscp_map_ff[2] <= reg_wdata[MAP_LO_POS +: MAP_W];
            dscp_map_ff[3] <= reg_wdata[MAP_HI_POS +: MAP_W];
        end else if (wr_map2) begin
            dscp_map_ff[4] <= reg_wdata[MAP_LO_POS +: MAP_W];
            dscp_map_ff[5] <= reg_wdata[MAP_HI_POS +: MAP_W];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ipv4_snoop_ff <= 1'b0;
            ipv6_snoop_ff <= 1'b0;
            mld_sel_ff <= 1'b0;
            mirror_and_ff <= 1'b0;
        end else if (wr_snoop) begin
            ipv4_snoop_ff <= reg_wdata[IPV4_EN_POS];
            ipv6_snoop_ff <= reg_wdata[IPV6_EN_POS];
            mld_sel_ff <= reg_wdata[MLD_SEL_POS];
            mirror_and_ff <= reg_wdata[MIRROR_AND_POS];
        end
    end

    // Colour values drive the queue manager straight from storage
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wred_red_dscp <= RED_RESET;
            wred_yellow_dscp <= YELLOW_RESET;
            wred_green_dscp <= GREEN_RESET;
        end else if (wr_wred) begin
            wred_red_dscp <= reg_wdata[RED_POS +: 2];
            wred_yellow_dscp <= reg_wdata[YELLOW_POS +: 2];
            wred_green_dscp <= reg_wdata[GREEN_POS +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ptp_evt_ovr_ff <= 1'b0;
            ptp_evt_prio_ff <= PTP_PRIO_RESET;
            ptp_gen_ovr_ff <= 1'b0;
            ptp_gen_prio_ff <= PTP_PRIO_RESET;
        end else begin
            if (wr_ptp_evt) begin
                ptp_evt_ovr_ff <= reg_wdata[PTP_OVR_POS];
                ptp_evt_prio_ff <= reg_wdata[PTP_PRIO_POS +: PRIO_W];
            end
            if (wr_ptp_gen) begin
                ptp_gen_ovr_ff <= reg_wdata[PTP_OVR_POS];
                ptp_gen_prio_ff <= reg_wdata[PTP_PRIO_POS +: PRIO_W];
            end
        end
    end

    // Read mux; reserved positions are constant zero
    always_comb begin
        nxt_rdata = READ_UNMAPPED;
        if (reg_addr == OFF_MAP_3A_3B) begin
            nxt_rdata = {1'b0, dscp_map_ff[1], 1'b0, dscp_map_ff[0]};
        end else if (reg_addr == OFF_MAP_3C_3D) begin
            nxt_rdata = {1'b0, dscp_map_ff[3], 1'b0, dscp_map_ff[2]};
        end else if (reg_addr == OFF_MAP_3E_3F) begin
            nxt_rdata = {1'b0, dscp_map_ff[5], 1'b0, dscp_map_ff[4]};
        end else if (reg_addr == OFF_MIRROR_SNOOP) begin
            nxt_rdata = {1'b0, ipv4_snoop_ff, 2'h0, mld_sel_ff, ipv6_snoop_ff,
                1'b0, mirror_and_ff};
        end else if (reg_addr == OFF_WRED_COLOUR) begin
            nxt_rdata = {2'h0, wred_red_dscp, wred_yellow_dscp, wred_green_dscp};
        end else if (reg_addr == OFF_PTP_EVENT) begin
            nxt_rdata = {ptp_evt_ovr_ff, 3'h0, ptp_evt_prio_ff};
        end else if (reg_addr == OFF_PTP_GENERAL) begin
            nxt_rdata = {ptp_gen_ovr_ff, 3'h0, ptp_gen_prio_ff};
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Classification uses settings as of the request cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            res_valid <= 1'b0;
            res_prio <= 4'h0;
            res_dscp_hit <= 1'b0;
            res_to_host <= 1'b0;
            res_mirror <= 1'b0;
        end else begin
            res_valid <= cls_valid;
            if (cls_valid) begin
                res_prio <= nxt_prio;
                res_dscp_hit <= nxt_dscp_hit;
                res_to_host <= nxt_to_host;
                res_mirror <= nxt_mirror;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    map_3a_a: assert property (
        cls_valid && cls_dscp == 6'h3A && !cls_ptp_event && !cls_ptp_general
        |=> res_valid && res_prio == {1'b0, $past(dscp_map_ff[0])}
    ) else $error("dscp 3A priority wrong");

    map_3d_a: assert property (
        cls_valid && cls_dscp == 6'h3D && !cls_ptp_event && !cls_ptp_general
        |=> res_prio == {1'b0, $past(dscp_map_ff[3])} && res_dscp_hit
    ) else $error("dscp 3D priority wrong");

    map_write_a: assert property (
        reg_wr && reg_addr == OFF_MAP_3E_3F ##1 cls_valid && cls_dscp == 6'h3F
        && !cls_ptp_event && !cls_ptp_general
        |=> res_prio == {1'b0, $past(reg_wdata[6:4], 2)}
    ) else $error("dscp 3F write not applied");

    map_rsvd_a: assert property (
        reg_rd && (reg_addr == OFF_MAP_3A_3B || reg_addr == OFF_MAP_3C_3D)
        |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0
    ) else $error("map reserved bit set");

    igmp_fwd_a: assert property (
        cls_valid && cls_is_igmp && !cls_is_ipv6 |=> res_to_host == $past(ipv4_snoop_ff)
    ) else $error("igmp forwarding wrong");

    mld_off_a: assert property (
        cls_valid && !cls_is_igmp && !ipv6_snoop_ff |=> !res_to_host
    ) else $error("listener snoop while disabled");

    mld_basic_a: assert property (
        cls_valid && cls_is_ipv6 && ipv6_snoop_ff && !mld_sel_ff
        && cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_ICMP6
        |=> res_to_host
    ) else $error("hop-by-hop 58 not matched");

    // Extended set spelled out apart from the matcher, so the check stays independent
    logic ext_crit_hit;
    assign ext_crit_hit = cls_next_hdr == NH_FRAGMENT
        || cls_next_hdr == NH_ESP || cls_next_hdr == NH_AUTH
        || cls_next_hdr == NH_ROUTING || cls_next_hdr == NH_DEST_OPT
        || (cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_DEST_OPT)
        || (cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_ROUTING)
        || (cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_FRAGMENT)
        || (cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_ESP)
        || (cls_next_hdr == NH_HOP_BY_HOP && cls_hbh_next_hdr == NH_AUTH);

    mld_ext_a: assert property (
        cls_valid && cls_is_ipv6 && !cls_is_igmp && ipv6_snoop_ff && mld_sel_ff
        |=> res_to_host == $past(ext_crit_hit)
    ) else $error("extended criteria mismatch");

    mirror_and_a: assert property (
        cls_valid && mirror_and_ff && (cls_src_match != cls_dst_match) |=> !res_mirror
    ) else $error("and mode mirrored one side");

    mirror_or_a: assert property (
        cls_valid && !mirror_and_ff && cls_src_match |=> res_mirror
    ) else $error("or mode missed source match");

    wred_wr_a: assert property (
        reg_wr && reg_addr == OFF_WRED_COLOUR
        |=> wred_red_dscp == $past(reg_wdata[5:4]) ##1 reg_rdata[7:6] == 2'h0 || !$past(reg_rd)
    ) else $error("colour map write wrong");

    ptp_evt_a: assert property (
        cls_valid && cls_ptp_event && ptp_evt_ovr_ff |=> res_prio == $past(ptp_evt_prio_ff)
    ) else $error("event override ignored");

    ptp_gen_a: assert property (
        cls_valid && cls_ptp_general && !cls_ptp_event && ptp_gen_ovr_ff
        |=> res_prio == $past(ptp_gen_prio_ff)
    ) else $error("general override ignored");

    snoop_rsvd_a: assert property (
        reg_rd && reg_addr == OFF_MIRROR_SNOOP
        |=> reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'h0 && reg_rdata[1] == 1'b0
    ) else $error("snoop reserved bit set");

    rsvd_write_a: assert property (
        reg_wr && reg_addr == OFF_PTP_EVENT ##1 reg_rd && reg_addr == OFF_PTP_EVENT
        |=> reg_rdata[6:4] == 3'h0 && reg_rdata[3:0] == $past(reg_wdata[3:0], 2)
    ) else $error("reserved write stored");

    cover_dscp_c: cover property (cls_valid && cls_dscp == 6'h3E ##1 res_dscp_hit);
    cover_ptp_c: cover property (cls_valid && cls_ptp_event && ptp_evt_ovr_ff);
    cover_mld_c: cover property (cls_valid && cls_is_ipv6 ##1 res_to_host);
    cover_and_c: cover property (cls_valid && mirror_and_ff ##1 res_mirror);
endmodule

// >>> qsm_pkg.sv
package qsm_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MAP_W = 3;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned MAP_N = 6;

    localparam logic [15:0] OFF_MAP_3A_3B = 16'h035D;
    localparam logic [15:0] OFF_MAP_3C_3D = 16'h035E;
    localparam logic [15:0] OFF_MAP_3E_3F = 16'h035F;
    localparam logic [15:0] OFF_MIRROR_SNOOP = 16'h0370;
    localparam logic [15:0] OFF_WRED_COLOUR = 16'h0378;
    localparam logic [15:0] OFF_PTP_EVENT = 16'h037C;
    localparam logic [15:0] OFF_PTP_GENERAL = 16'h037D;

    localparam logic [5:0] DSCP_FIRST = 6'h3A;
    localparam int unsigned MAP_LO_POS = 0;
    localparam int unsigned MAP_HI_POS = 4;
    localparam logic [2:0] MAP_RESET = 3'h0;

    localparam int unsigned IPV4_EN_POS = 6;
    localparam int unsigned MLD_SEL_POS = 3;
    localparam int unsigned IPV6_EN_POS = 2;
    localparam int unsigned MIRROR_AND_POS = 0;

    localparam int unsigned RED_POS = 4;
    localparam int unsigned YELLOW_POS = 2;
    localparam int unsigned GREEN_POS = 0;
    localparam logic [1:0] RED_RESET = 2'h3;
    localparam logic [1:0] YELLOW_RESET = 2'h2;
    localparam logic [1:0] GREEN_RESET = 2'h1;

    localparam int unsigned PTP_OVR_POS = 7;
    localparam int unsigned PTP_PRIO_POS = 0;
    localparam logic [3:0] PTP_PRIO_RESET = 4'hF;

    localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
    localparam logic [7:0] NH_ICMP4 = 8'h01;
    localparam logic [7:0] NH_ICMP6 = 8'h3A;
    localparam logic [7:0] NH_ROUTING = 8'h2B;
    localparam logic [7:0] NH_FRAGMENT = 8'h2C;
    localparam logic [7:0] NH_ESP = 8'h32;
    localparam logic [7:0] NH_AUTH = 8'h33;
    localparam logic [7:0] NH_DEST_OPT = 8'h3C;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

// >>> qsm_cfg_if.sv
`timescale 1ns/1ps
interface qsm_cfg_if;
    import qsm_pkg::*;
    logic [MAP_N-1:0][MAP_W-1:0] dscp_map;
    logic ipv4_group_snoop_en;
    logic ipv6_listener_snoop_en;
    logic mld_criteria_select;
    logic mirror_and_mode;
    logic ptp_event_ovr;
    logic [PRIO_W-1:0] ptp_event_prio;
    logic ptp_general_ovr;
    logic [PRIO_W-1:0] ptp_general_prio;

    modport cfg_src (
        output dscp_map, ipv4_group_snoop_en, ipv6_listener_snoop_en,
        output mld_criteria_select, mirror_and_mode,
        output ptp_event_ovr, ptp_event_prio, ptp_general_ovr, ptp_general_prio
    );
    modport cfg_use (
        input dscp_map, ipv4_group_snoop_en, ipv6_listener_snoop_en,
        input mld_criteria_select, mirror_and_mode,
        input ptp_event_ovr, ptp_event_prio, ptp_general_ovr, ptp_general_prio
    );
endinterface

// >>> qsm_prio_sel.sv
`timescale 1ns/1ps
module qsm_prio_sel (
    input wire logic [5:0] dscp,
    input wire logic [qsm_pkg::PRIO_W-1:0] qos_prio,
    input wire logic ptp_event,
    input wire logic ptp_general,
    qsm_cfg_if.cfg_use cfg,
    output logic [qsm_pkg::PRIO_W-1:0] prio,
    output logic dscp_hit
);
    import qsm_pkg::*;
    logic [5:0] dscp_off;
    logic [2:0] map_idx;

    assign dscp_off = dscp - DSCP_FIRST;
    assign map_idx = dscp_off[2:0];
    // Only code points 0x3A..0x3F live in this bank
    assign dscp_hit = (dscp >= DSCP_FIRST);

    always_comb begin
        prio = qos_prio;
        if (dscp_hit) begin
            prio = {1'b0, cfg.dscp_map[map_idx]};
        end
        // Event override checked first if a frame claims both kinds
        if (ptp_event && cfg.ptp_event_ovr) begin
            prio = cfg.ptp_event_prio;
        end else if (ptp_general && cfg.ptp_general_ovr) begin
            prio = cfg.ptp_general_prio;
        end
    end
endmodule

// >>> qsm_snoop_mirror.sv
`timescale 1ns/1ps
module qsm_snoop_mirror (
    input wire logic is_igmp,
    input wire logic is_ipv6,
    input wire logic [7:0] next_hdr,
    input wire logic [7:0] hbh_next_hdr,
    input wire logic src_match,
    input wire logic dst_match,
    qsm_cfg_if.cfg_use cfg,
    output logic to_host,
    output logic mirror
);
    import qsm_pkg::*;
    logic nh_hit;
    logic hbh_hit;
    logic mld_match;

    function automatic logic crit_hit(input logic sel, input logic [7:0] nh);
        if (sel) begin
            crit_hit = (nh == NH_ROUTING) || (nh == NH_FRAGMENT) || (nh == NH_ESP)
                || (nh == NH_AUTH) || (nh == NH_DEST_OPT);
        end else begin
            crit_hit = (nh == NH_ICMP4) || (nh == NH_ICMP6);
        end
    endfunction

    assign nh_hit = crit_hit(cfg.mld_criteria_select, next_hdr);
    assign hbh_hit = crit_hit(cfg.mld_criteria_select, hbh_next_hdr);
    assign mld_match = is_ipv6 && (nh_hit || ((next_hdr == NH_HOP_BY_HOP) && hbh_hit));

    always_comb begin
        to_host = (is_igmp && cfg.ipv4_group_snoop_en)
            || (mld_match && cfg.ipv6_listener_snoop_en);
        if (cfg.mirror_and_mode) begin
            mirror = src_match && dst_match;
        end else begin
            mirror = src_match || dst_match;
        end
    end
endmodule

// >>> test_qsm_top.sv
`timescale 1ns/1ps
module test_qsm_top;
    import qsm_pkg::*;
    typedef struct packed {
        logic [5:0] dscp;
        logic [3:0] qos;
        logic ev;
        logic gen;
        logic igmp;
        logic v6;
        logic [7:0] nh;
        logic [7:0] hbh;
        logic src;
        logic dst;
    } qsm_cls_s;
    typedef struct packed {logic [2:0] idx; logic [7:0] d; logic [7:0] e;} qsm_row_s;

    logic clock;
    logic resetn;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    qsm_cls_s c_in;
    logic cls_valid;
    logic res_valid;
    logic [3:0] res_prio;
    logic res_dscp_hit;
    logic res_to_host;
    logic res_mirror;
    logic [1:0] wred_red_dscp;
    logic [1:0] wred_yellow_dscp;
    logic [1:0] wred_green_dscp;
    int miscompares = 0;
    int checks = 0;
    logic [3:0] e_prio;
    logic e_hit;
    logic e_host;
    logic e_mir;
    // Index 7 is an unmapped byte between the snoop and colour registers
    logic [15:0] adr [0:7] = '{OFF_MAP_3A_3B, OFF_MAP_3C_3D, OFF_MAP_3E_3F, OFF_MIRROR_SNOOP,
        OFF_WRED_COLOUR, OFF_PTP_EVENT, OFF_PTP_GENERAL, 16'h0371};
    logic [7:0] msk [0:7] = '{8'h77, 8'h77, 8'h77, 8'h4D, 8'h3F, 8'h8F, 8'h8F, 8'h00};
    logic [7:0] rst [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h39, 8'h0F, 8'h0F, 8'h00};
    logic [7:0] sh [0:7];
    qsm_row_s rows [0:7] = '{'{3'h0, 8'hFF, 8'h77}, '{3'h1, 8'h5A, 8'h52},
        '{3'h2, 8'h35, 8'h35}, '{3'h3, 8'hFF, 8'h4D}, '{3'h4, 8'hFF, 8'h3F},
        '{3'h5, 8'hFF, 8'h8F}, '{3'h6, 8'h85, 8'h85}, '{3'h7, 8'hFF, 8'h00}};
    logic [7:0] nhs [0:9] = '{NH_ICMP4, NH_ICMP6, NH_ROUTING, NH_FRAGMENT, NH_ESP, NH_AUTH,
        NH_DEST_OPT, 8'h11, 8'h06, 8'h2D};
    logic [7:0] snoops [0:2] = '{8'h4D, 8'h44, 8'h08};

    qsm_top qsm_top_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cls_valid(cls_valid), .cls_dscp(c_in.dscp), .cls_qos_prio(c_in.qos),
        .cls_ptp_event(c_in.ev), .cls_ptp_general(c_in.gen), .cls_is_igmp(c_in.igmp),
        .cls_is_ipv6(c_in.v6), .cls_next_hdr(c_in.nh), .cls_hbh_next_hdr(c_in.hbh),
        .cls_src_match(c_in.src), .cls_dst_match(c_in.dst), .res_valid(res_valid),
        .res_prio(res_prio), .res_dscp_hit(res_dscp_hit), .res_to_host(res_to_host),
        .res_mirror(res_mirror), .wred_red_dscp(wred_red_dscp),
        .wred_yellow_dscp(wred_yellow_dscp), .wred_green_dscp(wred_green_dscp));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic in_set(input logic [7:0] v, input logic sel);
        if (sel) return v inside {NH_ROUTING, NH_FRAGMENT, NH_ESP, NH_AUTH, NH_DEST_OPT};
        return v inside {NH_ICMP4, NH_ICMP6};
    endfunction

    task automatic wr_now(input logic [2:0] i, input logic [7:0] d);
        reg_addr <= adr[i];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        sh[i] = d & msk[i];
    endtask

    task automatic bus_wr(input logic [2:0] i, input logic [7:0] d);
        @(posedge clock);
        wr_now(i, d);
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Starts right at the edge it is called on, so it may follow a write with no gap
    task automatic rd_go(input logic [2:0] i, input logic [7:0] exp);
        reg_addr <= adr[i];
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask

    task automatic bus_rd(input logic [2:0] i, input logic [7:0] exp);
        @(posedge clock);
        rd_go(i, exp);
    endtask

    // Expectation uses the register image as it stands before the request edge
    task automatic cls_set(input qsm_cls_s c);
        logic [7:0] r;
        logic [7:0] s;
        s = sh[3];
        c_in <= c;
        cls_valid <= 1'b1;
        e_hit = (c.dscp >= DSCP_FIRST);
        e_prio = c.qos;
        if (e_hit) begin
            r = sh[3'((c.dscp - DSCP_FIRST) >> 1)];
            e_prio = c.dscp[0] ? {1'b0, r[6:4]} : {1'b0, r[2:0]};
        end
        if (c.ev && sh[5][7]) e_prio = sh[5][3:0];
        else if (c.gen && sh[6][7]) e_prio = sh[6][3:0];
        e_host = (c.igmp & s[6]) | (c.v6 & s[2] & (in_set(c.nh, s[3])
            | ((c.nh == 8'h00) & in_set(c.hbh, s[3]))));
        e_mir = s[0] ? (c.src & c.dst) : (c.src | c.dst);
    endtask

    task automatic cls_end();
        @(posedge clock);
        cls_valid <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        chk("res_valid", 8'h01, {7'h00, res_valid});
        chk("res_prio", {4'h0, e_prio}, {4'h0, res_prio});
        chk("res_dscp_hit", {7'h00, e_hit}, {7'h00, res_dscp_hit});
        chk("res_to_host", {7'h00, e_host}, {7'h00, res_to_host});
        chk("res_mirror", {7'h00, e_mir}, {7'h00, res_mirror});
    endtask

    task automatic cls_go(input qsm_cls_s c);
        @(posedge clock);
        cls_set(c);
        cls_end();
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cls_valid = 1'b0;
        c_in = '0;
        sh = rst;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk("wred", 8'h39, {2'h0, wred_red_dscp, wred_yellow_dscp, wred_green_dscp});
        chk("res_valid", 8'h00, {7'h00, res_valid});
        for (int k = 0; k < 8; k++) bus_rd(3'(k), rst[k]);
        cls_go('{6'h3B, 4'h6, 1'b1, 1'b1, 1'b1, 1'b1, 8'h01, 8'h00, 1'b1, 1'b0});
        for (int k = 0; k < 8; k++) begin
            bus_wr(rows[k].idx, rows[k].d);
            rd_go(rows[k].idx, rows[k].e);
        end
        chk("wred", 8'h3F, {2'h0, wred_red_dscp, wred_yellow_dscp, wred_green_dscp});
        for (int d = 8'h38; d < 8'h40; d++)
            cls_go('{6'(d), 4'h9, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0});
        // Map write, then a request in the very next cycle
        @(posedge clock);
        wr_now(3'h2, 8'h60);
        @(posedge clock);
        reg_wr <= 1'b0;
        cls_set('{6'h3F, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0});
        cls_end();
        for (int k = 0; k < 4; k++)
            cls_go('{6'h3C, 4'h9, k[0], k[1], 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0});
        for (int v = 0; v < 3; v++) begin
            bus_wr(3'h3, snoops[v]);
            for (int j = 0; j < 20; j++)
                cls_go('{6'h01, 4'h3, 1'b0, 1'b0, j[0], (j != 5), (j < 10) ? nhs[j] : 8'h00,
                    (j < 10) ? 8'h11 : nhs[j - 10], j[1], j[2]});
        end
        // Write and request in one cycle: the request must still see the old override
        @(posedge clock);
        cls_set('{6'h10, 4'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0});
        wr_now(3'h5, 8'h0F);
        cls_end();
        cls_go('{6'h10, 4'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0});
        @(posedge clock);
        #1;
        chk("res_valid", 8'h00, {7'h00, res_valid});
        @(posedge clock);
        resetn <= 1'b0;
        @(posedge clock);
        resetn <= 1'b1;
        sh = rst;
        bus_rd(3'h4, 8'h39);
        @(posedge clock);
        #1;
        chk("reg_rdata", 8'h00, reg_rdata);
        bus_rd(3'h0, 8'h00);
        summarize();
    end
endmodule
